// [agc_gain2_cal.sv]
// Gain-2 calibration register bank with APB slave and result correction
//
// Register access over APB was left to the implementer.
module agc_gain2_cal (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [15:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic             O_PREADY,
  output logic [31:0]      O_PRDATA,
  output logic             O_PSLVERR,
  // Raw conversion from the converter, same clock
  input  wire logic        I_CONV_VALID,
  input  wire logic [15:0] I_CONV_DATA,
  input  wire logic        I_CONV_PGA_GAIN2,
  input  wire logic        I_CONV_CH_TIA,
  input  wire logic        I_CONV_CH_TEMP,
  // Corrected conversion
  output logic             O_RESULT_VALID,
  output logic [15:0]      O_CONVERSION_RESULT_DATA
);

  localparam int unsigned CW = agc_pkg::CAL_FIELD_WIDTH;
  localparam int unsigned DW = agc_pkg::RESULT_WIDTH;

  logic [CW-1:0] gain2_gain_correction_q;
  logic [CW-1:0] gain2_offset_correction_q;
  logic [DW-1:0] conversion_result_data_q;
  logic          pready_q;
  logic [31:0]   prdata_q;
  logic          pslverr_q;
  logic          corr_valid;
  logic [DW-1:0] corr_data;

  // Address decode
  wire sel_gain   = I_PADDR == agc_pkg::GAIN2_GAIN_CORRECTION_ADDR;
  wire sel_offset = I_PADDR == agc_pkg::GAIN2_OFFSET_CORRECTION_ADDR;
  wire sel_result = I_PADDR == agc_pkg::CONVERSION_RESULT_DATA_ADDR;
  wire mapped     = sel_gain | sel_offset | sel_result;
  // One wait state so that every bus output comes from a flip-flop
  wire access     = I_PSEL & I_PENABLE & ~pready_q;
  // Writes land at the edge where the master sees ready, not one edge early
  wire done       = I_PSEL & I_PENABLE & pready_q;
  wire wr_gain    = done & I_PWRITE & sel_gain;
  wire wr_offset  = done & I_PWRITE & sel_offset;

  // Read mux; upper bits stay zero
  wire [31:0] rd_data = sel_gain   ? {17'h0_0000, gain2_gain_correction_q} :
                        sel_offset ? {17'h0_0000, gain2_offset_correction_q} :
                        sel_result ? {16'h0000, conversion_result_data_q} :
                                     32'h0000_0000;

  // Calibration registers; only bits 14..0 of a write are kept
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      gain2_gain_correction_q   <= agc_pkg::GAIN_RESET;
      gain2_offset_correction_q <= agc_pkg::OFFSET_RESET;
    end else begin
      if (wr_gain) begin
        gain2_gain_correction_q <= I_PWDATA[CW-1:0];
      end
      if (wr_offset) begin
        gain2_offset_correction_q <= I_PWDATA[CW-1:0];
      end
    end
  end

  // Bus answer: ready one cycle into the access phase, error on unmapped
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access & ~mapped;
      if (access & ~I_PWRITE) begin
        prdata_q <= rd_data;
      end
    end
  end

  // Correction sits in front of the result register
  agc_corrector #(
    .DATA_W (DW),
    .CAL_W  (CW)
  ) u_corrector (
    .i_clk       (I_CORE_CLK),
    .i_rst       (I_RST),
    .i_valid     (I_CONV_VALID),
    .i_data      (I_CONV_DATA),
    .i_gain2     (I_CONV_PGA_GAIN2),
    .i_skip_gain (I_CONV_CH_TIA | I_CONV_CH_TEMP),
    .i_gain      (gain2_gain_correction_q),
    .i_offset    (gain2_offset_correction_q),
    .o_valid     (corr_valid),
    .o_data      (corr_data)
  );

  // Result register readable by software
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      conversion_result_data_q <= agc_pkg::RESULT_RESET;
    end else if (corr_valid) begin
      conversion_result_data_q <= corr_data;
    end
  end

  assign O_PREADY                 = pready_q;
  assign O_PRDATA                 = prdata_q;
  assign O_PSLVERR                = pslverr_q;
  assign O_RESULT_VALID           = corr_valid;
  assign O_CONVERSION_RESULT_DATA = corr_data;

endmodule // agc_gain2_cal

// [agc_pkg.sv]
// Constants shared by the gain-2 calibration register bank and its datapath
// Notes on behaviour
// - Offset field is 15-bit two's complement, one step is a quarter result LSB.
// - Offset 0x3FFF adds 4095.75, 0x7FFF subtracts 0.25, 0x4000 subtracts 4096.
// - Offset correction acts only on conversions taken with amplifier gain 2.
// - Gain field is fixed point, bits 13..0 fractional, scales the result.
// - Gain 0x4000 is unity, 0x2000 half, 0x7FFF nearly two, 0x0001 tiny.
// - Gain code zero is illegal and forces the corrected gain-2 result to zero, except on the transimpedance and temperature channels.
// - Gain correction skips the transimpedance and temperature sensor channels.
// - Reset leaves gain at unity and offset at zero, so results pass unchanged.
package agc_pkg;

  // Register byte addresses
  localparam logic [15:0] GAIN2_GAIN_CORRECTION_ADDR   = 16'h2274;
  localparam logic [15:0] GAIN2_OFFSET_CORRECTION_ADDR = 16'h22c8;
  localparam logic [15:0] CONVERSION_RESULT_DATA_ADDR  = 16'h2300;

  // Field layout
  localparam int unsigned CAL_FIELD_WIDTH = 15;
  localparam int unsigned GAIN_FRAC_BITS  = 14;
  localparam int unsigned OFFSET_FRAC_BITS = 2;
  localparam int unsigned RESULT_WIDTH    = 16;

  // Reset values
  localparam logic [14:0] GAIN_RESET   = 15'h4000;
  localparam logic [14:0] OFFSET_RESET = 15'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Unity gain, used for channels that take offset only
  localparam logic [14:0] GAIN_UNITY = 15'h4000;

endpackage : agc_pkg

// [agc_corrector.sv]
// Two-stage offset and gain correction pipeline for one conversion result
module agc_corrector #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned CAL_W  = 15
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_valid,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_gain2,
  input  wire logic              i_skip_gain,
  input  wire logic [CAL_W-1:0]  i_gain,
  input  wire logic [CAL_W-1:0]  i_offset,
  output logic                   o_valid,
  output logic [DATA_W-1:0]      o_data
);

  localparam int unsigned SUM_W  = DATA_W + 5;
  localparam int unsigned PROD_W = SUM_W + CAL_W + 1;
  localparam int unsigned SHIFT  = agc_pkg::GAIN_FRAC_BITS + agc_pkg::OFFSET_FRAC_BITS;

  logic                     s1_valid_q;
  logic                     s1_gain2_q;
  logic [DATA_W-1:0]        s1_raw_q;
  logic signed [SUM_W-1:0]  s1_sum_q;
  logic [CAL_W-1:0]         s1_gain_q;

  // Result in quarter LSBs plus sign-extended offset code
  wire signed [SUM_W-1:0] raw_quarter = $signed({3'b000, i_data, 2'b00});
  wire signed [SUM_W-1:0] off_ext = SUM_W'($signed(i_offset));
  wire signed [SUM_W-1:0] sum_d   = i_gain2 ? raw_quarter + off_ext : raw_quarter;
  // Excluded channels see unity gain, so only the offset reaches them
  wire [CAL_W-1:0] gain_eff = i_skip_gain ? agc_pkg::GAIN_UNITY : i_gain;

  // Stage 1: offset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_valid_q <= 1'b0;
      s1_gain2_q <= 1'b0;
      s1_raw_q   <= '0;
      s1_sum_q   <= '0;
      s1_gain_q  <= agc_pkg::GAIN_RESET;
    end else begin
      s1_valid_q <= i_valid;
      if (i_valid) begin
        s1_gain2_q <= i_gain2;
        s1_raw_q   <= i_data;
        s1_sum_q   <= sum_d;
        s1_gain_q  <= gain_eff;
      end
    end
  end

  // Gain is unsigned fixed point: code / 2^14, rounded to nearest LSB
  wire signed [PROD_W-1:0] prod = PROD_W'(s1_sum_q) * $signed({1'b0, s1_gain_q});
  wire signed [PROD_W-1:0] rnd  = prod + $signed(PROD_W'(64'd1 << (SHIFT - 1)));
  wire signed [PROD_W-1:0] scaled = rnd >>> SHIFT;
  // Clamp into the unsigned result range; wrap would turn overrange into noise
  wire sat_lo = scaled < 0;
  wire sat_hi = scaled > $signed(PROD_W'({DATA_W{1'b1}}));
  wire [DATA_W-1:0] clamped = sat_lo ? '0 : (sat_hi ? '1 : scaled[DATA_W-1:0]);
  wire [DATA_W-1:0] res_d = !s1_gain2_q ? s1_raw_q :
                            (s1_gain_q == '0) ? '0 : clamped;

  // Stage 2: gain and clamp
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data  <= agc_pkg::RESULT_RESET;
    end else begin
      o_valid <= s1_valid_q;
      if (s1_valid_q) begin
        o_data <= res_d;
      end
    end
  end

endmodule // agc_corrector

// [agc_gain2_cal_asserts.sv]
// Port-level checks for the gain-2 calibration bank
module agc_gain2_cal_chk (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [15:0] I_PADDR,
  input wire logic        O_PREADY,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PSLVERR,
  input wire logic        I_CONV_VALID,
  input wire logic [15:0] I_CONV_DATA,
  input wire logic        I_CONV_PGA_GAIN2,
  input wire logic        O_RESULT_VALID,
  input wire logic [15:0] O_CONVERSION_RESULT_DATA
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // Map decode, so a refused access is known here
  wire logic hit = I_PADDR inside {16'h2274, 16'h22c8, 16'h2300};
  sequence s_acc; I_PSEL && I_PENABLE && !O_PREADY; endsequence
  sequence s_res; ##2 O_RESULT_VALID; endsequence
  property p_ready; s_acc |=> O_PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_pulse; O_PREADY |=> !O_PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err; O_PREADY |-> O_PSLVERR == !hit; endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  // Result register is a full 16-bit word, so only bits 31..16 are reserved there
  property p_rsv; O_PREADY && !I_PWRITE |-> O_PRDATA[31:15] == 17'h0_0000 ||
    (I_PADDR == 16'h2300 && O_PRDATA[31:16] == 16'h0000); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_miss; O_PREADY && !I_PWRITE && !hit |-> O_PRDATA == 32'h0000_0000; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read data");
  property p_lat; I_CONV_VALID |-> s_res; endproperty
  a_lat: assert property (p_lat) else $error("result late");
  property p_idle; !I_CONV_VALID |-> ##2 !O_RESULT_VALID; endproperty
  a_idle: assert property (p_idle) else $error("stray result");
  property p_pass; I_CONV_VALID && !I_CONV_PGA_GAIN2 |->
    s_res ##0 O_CONVERSION_RESULT_DATA == $past(I_CONV_DATA, 2); endproperty
  a_pass: assert property (p_pass) else $error("other gain altered");
endmodule // agc_gain2_cal_chk
bind agc_gain2_cal agc_gain2_cal_chk i_chk (.*);

// [testbench.sv]
// Self-checking bench for the gain-2 calibration bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CORE_CLK, I_RST, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR, O_RESULT_VALID;
  logic I_CONV_VALID, I_CONV_PGA_GAIN2, I_CONV_CH_TIA, I_CONV_CH_TEMP;
  logic [15:0] I_PADDR, I_CONV_DATA, O_CONVERSION_RESULT_DATA;
  logic [31:0] I_PWDATA, O_PRDATA;
  logic [32:0] qa[$];
  logic [15:0] qr[$];
  logic [14:0] gn, of;
  logic [14:0] oc[5] = '{15'h3fff, 15'h0001, 15'h0000, 15'h7fff, 15'h4000};
  logic [14:0] gc[7] = '{15'h0000, 15'h2000, 15'h4000, 15'h4001, 15'h7fff, 15'h3fff, 15'h0001};
  int n_mismatch, checks_done;
  agc_gain2_cal i_agc_gain2_cal (.*);
  // 25 MHz core clock
  initial begin
    I_CORE_CLK = 0;
    forever #20 I_CORE_CLK = ~I_CORE_CLK;
  end
  task automatic cmp_apb(logic [32:0] e, logic [32:0] g);
    checks_done++;
    if (e !== g) begin
      n_mismatch++;
      $display("wrong value apb expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_res(string s, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (e !== g) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Oldest note is taken whenever an answer appears; write data is not compared
  always @(posedge I_CORE_CLK) begin
    if (O_PREADY === 1)
      cmp_apb(qa.pop_front(), {O_PSLVERR, I_PWRITE ? 32'h0000_0000 : O_PRDATA});
    if (O_RESULT_VALID === 1)
      cmp_res("result", qr.pop_front(), O_CONVERSION_RESULT_DATA);
  end
  // Request held until ready is sampled; select stays up only for a following setup
  task automatic apb(bit w, logic [15:0] a, logic [31:0] d, logic [32:0] e);
    qa.push_back(e);
    {I_PSEL, I_PWRITE, I_PADDR, I_PWDATA} <= {1'b1, w, a, d};
    @(posedge I_CORE_CLK);
    I_PENABLE <= 1;
    do @(posedge I_CORE_CLK); while (O_PREADY !== 1);
    I_PENABLE <= 0;
  endtask
  // Offset in quarter steps, gain over 2^14, half-up rounding and clamping
  function automatic logic [15:0] mdl(logic [15:0] r, bit g2, bit ex);
    longint p;
    if (!g2) return r;
    p = (longint'(r) * 4 + longint'($signed(of))) * (ex ? 64'sd16384 : longint'(gn));
    p = (p + 32768) >>> 16;
    return p < 0 ? 16'h0000 : p > 65535 ? 16'hffff : 16'(p);
  endfunction
  // Select drops as no setup follows; valid stays high for back-to-back conversions
  task automatic conv(logic [15:0] r, bit g2, bit ti, bit te);
    qr.push_back(mdl(r, g2, ti | te));
    {I_PSEL, I_CONV_VALID, I_CONV_PGA_GAIN2, I_CONV_CH_TIA, I_CONV_CH_TEMP, I_CONV_DATA} <=
      {1'b0, 1'b1, g2, ti, te, r};
    @(posedge I_CORE_CLK);
  endtask
  initial begin
    {I_RST, I_PSEL, I_PENABLE, I_PWRITE, I_CONV_VALID} = 5'h10;
    {I_CONV_PGA_GAIN2, I_CONV_CH_TIA, I_CONV_CH_TEMP, I_PADDR, I_PWDATA, I_CONV_DATA} = '0;
    {gn, of} = {15'h4000, 15'h0000};
    void'($urandom(32'h49fc));
    repeat (5) @(posedge I_CORE_CLK);
    I_RST <= 0;
    @(posedge I_CORE_CLK);
    // Reset contents, an untouched conversion, refused and ignored accesses
    apb(0, 16'h2274, $urandom, 33'h0_0000_4000);
    apb(0, 16'h22c8, $urandom, 33'h0_0000_0000);
    apb(0, 16'h2300, $urandom, 33'h0_0000_0000);
    conv(16'h04d2, 1, 0, 0);
    I_CONV_VALID <= 0;
    apb(0, 16'h2278, $urandom, 33'h1_0000_0000);
    apb(1, 16'h2270, $urandom, 33'h1_0000_0000);
    apb(1, 16'h2300, $urandom, 33'h0_0000_0000);
    apb(0, 16'h2300, $urandom, 33'h0_0000_04d2);
    // Every printed code, written with the reserved bits set, on each channel kind
    for (int i = 0; i < 7; i++) begin
      of = oc[i % 5];
      gn = gc[i];
      apb(1, 16'h22c8, {17'h1_ffff, of}, '0);
      apb(1, 16'h2274, {17'h1_ffff, gn}, '0);
      apb(0, 16'h22c8, $urandom, {18'h0_0000, of});
      apb(0, 16'h2274, $urandom, {18'h0_0000, gn});
      conv(16'h4e20, 1, 0, 0);
      for (int j = 0; j < 4; j++) conv(16'($urandom), j != 3, j == 1, j == 2);
      I_CONV_VALID <= 0;
    end
    I_PSEL <= 0;
    repeat (4) @(posedge I_CORE_CLK);
    // Every noted answer must have appeared by now
    cmp_res("pending notes", 16'h0000, 16'(qa.size() + qr.size()));
    final_report();
  end
  // Whole run is about 150 cycles; this limit only catches a hang
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
endmodule // testbench
